// ### shared/srp_pkg.sv
// Shared constants, register map and checksum step for the serial register port.
package srp_pkg;
  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [6:0] ADDR_CFG_ONE = 7'h00;
  localparam logic [6:0] ADDR_CFG_TWO = 7'h01;
  localparam logic [6:0] ADDR_CFG_THREE = 7'h02;
  localparam logic [6:0] ADDR_CHECKSUM_CFG = 7'h03;
  localparam logic [6:0] ADDR_CLOCK_CFG = 7'h04;
  localparam logic [6:0] ADDR_MON_ENABLE = 7'h05;
  localparam logic [6:0] ADDR_TRIP_TEST = 7'h06;
  localparam logic [6:0] CFG_COUNT = 7'h08;
  localparam logic [6:0] ADDR_GEN_ERR_ONE = 7'h08;
  localparam logic [6:0] ADDR_GEN_ERR_TWO = 7'h09;
  localparam logic [6:0] ADDR_STATUS_ONE = 7'h16;
  localparam logic [6:0] ADDR_STATUS_TWO = 7'h17;
  localparam logic [6:0] REG_COUNT = 7'h18;
  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int unsigned AUX_POWER_BIT = 3;
  localparam int unsigned AUX_MODE_BIT = 5;
  localparam int unsigned MAIN_MODE_BIT = 4;
  localparam int unsigned CRC_EN_BIT = 0;
  localparam int unsigned CLK_CHECK_DIS_BIT = 0;
  localparam int unsigned EV_READ = 0;
  localparam int unsigned EV_CRC = 1;
  localparam int unsigned EV_INV_RD = 2;
  localparam int unsigned EV_INV_WR = 3;
  localparam int unsigned EV_SWRST = 4;
  localparam int unsigned EV_COUNT = 5;
  // ************************************************************
  // Reset values, frame counts and codes
  // ************************************************************
  localparam logic [7:0][7:0] CFG_RESET = {8'h00, 8'h00, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [4:0] ADDR_END = 5'h08;
  localparam logic [4:0] DATA_END = 5'h10;
  localparam logic [4:0] CRC_END = 5'h18;
  localparam logic [6:0] SW_RESET_ONES = 7'h40;
  localparam logic [7:0] HDR_REG = 8'h20;
  localparam logic [3:0] HDR_AUX = 4'h2;
  localparam logic [7:0] CRC_POLY = 8'h07;

  function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic din);
    crc_step = {crc[6:0], 1'b0} ^ (((crc[7] ^ din) == 1'b1) ? CRC_POLY : 8'h00);
  endfunction
endpackage

// ### design/srp_port.sv
// Serial register port with conversion readback and fault reporting.
`timescale 1ns/10ps
`default_nettype none

// ************************************************************
// Frame logic, cleared whenever chip select is high
// ************************************************************
module srp_link (
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic sdi_i,
  input wire logic crc_en_i,
  input wire logic aux_mode_i,
  input wire logic main_mode_i,
  input wire logic [7:0] rd_byte_i,
  input wire logic [11:0] aux_word_i,
  output logic [6:0] addr_o,
  output logic rd_now_o,
  output logic wr_now_o,
  output logic [7:0] wdata_o,
  output logic crc_bad_o,
  output logic bit_o
);
  typedef struct packed {
    logic [4:0] cnt;
    logic [15:0] sh;
    logic rd;
    logic [6:0] addr;
    logic [7:0] dbyte;
    logic [7:0] crc_in;
    logic [7:0] crc_out;
  } srp_link_t;

  srp_link_t q;
  srp_link_t next_q;
  logic [4:0] p;
  logic [4:0] flen;
  logic [15:0] word;
  logic [7:0] rx_crc;

  always_comb begin
    next_q = q;
    p = (q.cnt == 5'h1f) ? q.cnt : q.cnt + 5'h01;
    next_q.cnt = p;
    next_q.sh = {q.sh[14:0], sdi_i};
    addr_o = q.addr;
    rd_now_o = 1'b0;
    wr_now_o = 1'b0;
    crc_bad_o = 1'b0;
    wdata_o = {q.sh[6:0], sdi_i};
    rx_crc = {q.sh[6:0], sdi_i};
    if (q.cnt < srp_pkg::DATA_END) begin
      next_q.crc_in = srp_pkg::crc_step(q.crc_in, sdi_i);
    end
    if (q.cnt == srp_pkg::ADDR_END - 5'h01) begin
      addr_o = {q.sh[5:0], sdi_i};
      next_q.rd = q.sh[6];
      next_q.addr = addr_o;
      rd_now_o = q.sh[6] & ~aux_mode_i & ~main_mode_i;
      next_q.dbyte = rd_now_o ? rd_byte_i : 8'h00;
    end
    if (!q.rd && !crc_en_i && q.cnt == srp_pkg::DATA_END - 5'h01) begin
      wr_now_o = 1'b1;
    end
    if (!q.rd && crc_en_i && q.cnt == srp_pkg::CRC_END - 5'h01) begin
      wdata_o = q.sh[14:7];
      wr_now_o = (rx_crc == q.crc_in);
      crc_bad_o = ~wr_now_o;
    end
    // Bit 0 of every frame is a zero header bit shown from chip select,
    // so starting the output checksum at zero already accounts for it.
    flen = crc_en_i ? srp_pkg::CRC_END : srp_pkg::DATA_END;
    word = aux_mode_i ? {srp_pkg::HDR_AUX, aux_word_i} : {srp_pkg::HDR_REG, next_q.dbyte};
    bit_o = 1'b0;
    if (p < srp_pkg::DATA_END) begin
      bit_o = word[~p[3:0]];
      next_q.crc_out = srp_pkg::crc_step(q.crc_out, bit_o);
    end else if (p < flen) begin
      bit_o = q.crc_out[7];
      next_q.crc_out = {q.crc_out[6:0], 1'b0};
    end
  end

  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
endmodule

// ************************************************************
// Serial clock state that outlives frames
// ************************************************************
module srp_keep (
  input wire logic sclk_i,
  input wire logic rstn_i,
  input wire logic sdi_i,
  input wire logic [63:0] main_word_i,
  input wire logic [15:0][7:0] err_bytes_i,
  input wire logic [6:0] addr_i,
  input wire logic rd_now_i,
  input wire logic wr_now_i,
  input wire logic [7:0] wdata_i,
  input wire logic crc_bad_i,
  input wire logic bit_i,
  output logic sdo_o,
  output logic [7:0][7:0] cfg_o,
  output logic [4:0] evt_o,
  output logic [6:0] rd_addr_o,
  output logic [7:0] rd_byte_o
);
  typedef struct packed {
    logic [1:0] rst_s;
    logic [7:0][7:0] cfg;
    logic [15:0][7:0] err_s1;
    logic [15:0][7:0] err_s2;
    logic [6:0] ones;
    logic [5:0] ptr;
    logic main_q;
    logic sdo;
    logic [4:0] evt;
    logic [6:0] rd_addr;
  } srp_keep_t;

  srp_keep_t q;
  srp_keep_t next_q;
  logic main;
  logic [6:0] eidx;

  always_comb begin
    next_q = q;
    next_q.rst_s = {q.rst_s[0], rstn_i};
    next_q.err_s1 = err_bytes_i;
    next_q.err_s2 = q.err_s1;
    eidx = addr_i - srp_pkg::CFG_COUNT;
    rd_byte_o = 8'h00;
    if (addr_i < srp_pkg::CFG_COUNT) begin
      rd_byte_o = q.cfg[addr_i[2:0]];
    end else if (addr_i < srp_pkg::REG_COUNT) begin
      rd_byte_o = q.err_s2[eidx[3:0]];
    end
    next_q.ones = !sdi_i ? 7'h00 : (q.ones == srp_pkg::SW_RESET_ONES) ? q.ones : q.ones + 7'h01;
    if (wr_now_i) begin
      if (addr_i < srp_pkg::CFG_COUNT) begin
        next_q.cfg[addr_i[2:0]] = wdata_i;
      end else if (addr_i >= srp_pkg::REG_COUNT) begin
        next_q.evt[srp_pkg::EV_INV_WR] = ~q.evt[srp_pkg::EV_INV_WR];
      end
    end
    if (crc_bad_i) begin
      next_q.evt[srp_pkg::EV_CRC] = ~q.evt[srp_pkg::EV_CRC];
    end
    if (rd_now_i) begin
      next_q.rd_addr = addr_i;
      if (addr_i < srp_pkg::REG_COUNT) begin
        next_q.evt[srp_pkg::EV_READ] = ~q.evt[srp_pkg::EV_READ];
      end else begin
        next_q.evt[srp_pkg::EV_INV_RD] = ~q.evt[srp_pkg::EV_INV_RD];
      end
    end
    if (sdi_i && q.ones == srp_pkg::SW_RESET_ONES - 7'h01) begin
      next_q.cfg = srp_pkg::CFG_RESET;
      next_q.evt[srp_pkg::EV_SWRST] = ~q.evt[srp_pkg::EV_SWRST];
    end
    main = next_q.cfg[srp_pkg::ADDR_CFG_THREE[2:0]][srp_pkg::MAIN_MODE_BIT]
      & ~next_q.cfg[srp_pkg::ADDR_CFG_TWO[2:0]][srp_pkg::AUX_MODE_BIT];
    // The stream pointer survives chip select so a 64-bit word may be read
    // as several shorter frames.
    if (main && !q.main_q) begin
      next_q.ptr = 6'h00;
      next_q.sdo = main_word_i[63];
    end else if (main) begin
      next_q.ptr = q.ptr + 6'h01;
      next_q.sdo = main_word_i[~next_q.ptr];
    end else begin
      next_q.sdo = bit_i;
    end
    next_q.main_q = main;
    if (!q.rst_s[1]) begin
      next_q.cfg = srp_pkg::CFG_RESET;
      next_q.ones = 7'h00;
      next_q.ptr = 6'h00;
      next_q.main_q = 1'b0;
      next_q.sdo = 1'b0;
      next_q.evt = 5'h00;
      next_q.rd_addr = 7'h00;
    end
  end

  always_ff @(posedge sclk_i) begin
    q <= next_q;
  end

  assign sdo_o = q.sdo;
  assign cfg_o = q.cfg;
  assign evt_o = q.evt;
  assign rd_addr_o = q.rd_addr;
endmodule

// ************************************************************
// Top: master clock side, fault reporting and crossings
// ************************************************************
module srp_port (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic sdi_i,
  input wire logic sync_in_i,
  input wire logic handover_fail_i,
  input wire logic [2:0] reg_mon_i,
  input wire logic [63:0] chan_fault_i,
  input wire logic [31:0] sat_fault_i,
  input wire logic [63:0] main_data_i,
  input wire logic main_valid_i,
  input wire logic [11:0] aux_data_i,
  input wire logic aux_valid_i,
  output logic sdo_o,
  output logic fault_alert_out_o,
  output logic header_fault_o,
  output logic aux_power_on_o,
  output logic soft_reset_o
);
  typedef struct packed {
    logic [101:0] pa;
    logic [101:0] pb;
    logic [101:0] pc;
    logic [101:0] pin;
    logic [68:0] xa;
    logic [68:0] xb;
    logic [68:0] xc;
    logic [68:0] x;
    logic [4:0] ev_prev;
    logic sync_prev;
    logic [2:0] ser;
    logic handover;
    logic reset_seen;
    logic summary;
    logic [63:0] main_snap;
    logic [11:0] aux_snap;
    logic [15:0][7:0] err;
    logic alert;
    logic hdr;
    logic aux_pwr;
    logic soft_rst;
  } srp_port_t;

  srp_port_t q;
  srp_port_t next_q;
  logic [7:0][7:0] cfg;
  logic [7:0][7:0] cfg_k;
  logic [4:0] ev;
  logic [4:0] evt_k;
  logic [2:0] mon;
  logic rd_gen1;
  logic rd_gen2;
  logic rd_stat;
  logic fault;
  logic [6:0] rd_addr_k;
  logic [6:0] l_addr;
  logic l_rd;
  logic l_wr;
  logic [7:0] l_wdata;
  logic l_crc_bad;
  logic l_bit;
  logic [7:0] k_byte;

  always_comb begin
    next_q = q;
    // Pins and serial-side levels pass three stages; a change counts once
    // stages two and three agree, which rejects single-cycle metastability.
    next_q.pa = {sat_fault_i, chan_fault_i, reg_mon_i, handover_fail_i, sync_in_i, cs_n_i};
    next_q.pb = q.pa;
    next_q.pc = q.pb;
    next_q.pin = (q.pb & q.pc) | (q.pin & (q.pb | q.pc));
    next_q.xa = {cfg_k, evt_k};
    next_q.xb = q.xa;
    next_q.xc = q.xb;
    next_q.x = (q.xb & q.xc) | (q.x & (q.xb | q.xc));
    cfg = q.x[68:5];
    ev = q.x[4:0] ^ q.ev_prev;
    next_q.ev_prev = q.x[4:0];
    next_q.sync_prev = q.pin[1];
    // The read address is held by the serial side for a whole frame, far
    // longer than the event takes to cross, so it is sampled directly.
    rd_gen1 = ev[srp_pkg::EV_READ] && rd_addr_k == srp_pkg::ADDR_GEN_ERR_ONE;
    rd_gen2 = ev[srp_pkg::EV_READ] && rd_addr_k == srp_pkg::ADDR_GEN_ERR_TWO;
    rd_stat = ev[srp_pkg::EV_READ]
      && (rd_addr_k == srp_pkg::ADDR_STATUS_ONE || rd_addr_k == srp_pkg::ADDR_STATUS_TWO);
    mon = cfg[srp_pkg::ADDR_MON_ENABLE[2:0]][2:0]
      & (q.pin[5:3] | cfg[srp_pkg::ADDR_TRIP_TEST[2:0]][2:0]);
    next_q.handover = (q.handover | q.pin[2])
      & ~cfg[srp_pkg::ADDR_CLOCK_CFG[2:0]][srp_pkg::CLK_CHECK_DIS_BIT];
    next_q.reset_seen = ev[srp_pkg::EV_SWRST]
      | (q.reset_seen & ~(rd_gen2 | (q.pin[1] != q.sync_prev)));
    next_q.ser = {ev[srp_pkg::EV_INV_WR], ev[srp_pkg::EV_INV_RD], ev[srp_pkg::EV_CRC]}
      | (q.ser & {3{~rd_gen1}});
    next_q.err[0] = {5'h00, next_q.ser};
    next_q.err[1] = {3'h0, mon, next_q.reset_seen, next_q.handover};
    for (int i = 0; i < 8; i++) begin
      next_q.err[2 + i] = q.pin[6 + 8 * i +: 8];
      next_q.err[14][i] = |q.pin[6 + 8 * i +: 8];
    end
    for (int i = 0; i < 4; i++) begin
      next_q.err[10 + i] = q.pin[70 + 8 * i +: 8];
      next_q.err[15][2 + i] = |q.pin[70 + 8 * i +: 8];
    end
    next_q.err[15][0] = |next_q.err[0];
    next_q.err[15][1] = |next_q.err[1];
    // The reset indicator is not a fault, so it does not raise the alert.
    fault = |{next_q.ser, mon, next_q.handover, q.pin[101:6]};
    next_q.summary = fault | (q.summary & ~rd_stat);
    next_q.err[15][6] = next_q.summary;
    next_q.err[15][7] = 1'b0;
    next_q.alert = fault;
    next_q.hdr = fault;
    if (q.pin[0]) begin
      if (main_valid_i) begin
        next_q.main_snap = main_data_i;
      end
      if (aux_valid_i) begin
        next_q.aux_snap = aux_data_i;
      end
    end
    next_q.aux_pwr = cfg[srp_pkg::ADDR_CFG_ONE[2:0]][srp_pkg::AUX_POWER_BIT];
    next_q.soft_rst = ev[srp_pkg::EV_SWRST];
    if (!rstn_i) begin
      next_q = '0;
      next_q.reset_seen = 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    q <= next_q;
  end

  srp_link u_link (
    .sclk_i(sclk_i),
    .cs_n_i(cs_n_i),
    .sdi_i(sdi_i),
    .crc_en_i(cfg_k[srp_pkg::ADDR_CHECKSUM_CFG[2:0]][srp_pkg::CRC_EN_BIT]),
    .aux_mode_i(cfg_k[srp_pkg::ADDR_CFG_TWO[2:0]][srp_pkg::AUX_MODE_BIT]),
    .main_mode_i(cfg_k[srp_pkg::ADDR_CFG_THREE[2:0]][srp_pkg::MAIN_MODE_BIT]),
    .rd_byte_i(k_byte),
    .aux_word_i(q.aux_snap),
    .addr_o(l_addr),
    .rd_now_o(l_rd),
    .wr_now_o(l_wr),
    .wdata_o(l_wdata),
    .crc_bad_o(l_crc_bad),
    .bit_o(l_bit)
  );

  srp_keep u_keep (
    .sclk_i(sclk_i),
    .rstn_i(rstn_i),
    .sdi_i(sdi_i),
    .main_word_i(q.main_snap),
    .err_bytes_i(q.err),
    .addr_i(l_addr),
    .rd_now_i(l_rd),
    .wr_now_i(l_wr),
    .wdata_i(l_wdata),
    .crc_bad_i(l_crc_bad),
    .bit_i(l_bit),
    .sdo_o(sdo_o),
    .cfg_o(cfg_k),
    .evt_o(evt_k),
    .rd_addr_o(rd_addr_k),
    .rd_byte_o(k_byte)
  );

  assign fault_alert_out_o = q.alert;
  assign header_fault_o = q.hdr;
  assign aux_power_on_o = q.aux_pwr;
  assign soft_reset_o = q.soft_rst;
endmodule

`default_nettype wire

// ### dv/srp_monitor.sv
// Concurrent checks on the ports of the serial register port top.
`timescale 1ns/10ps
`default_nettype none
module srp_monitor (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic [63:0] chan_fault_i,
  input wire logic [31:0] sat_fault_i,
  input wire logic fault_alert_out_o,
  input wire logic header_fault_o,
  input wire logic aux_power_on_o,
  input wire logic soft_reset_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);
  logic raw_quiet;
  assign raw_quiet = (chan_fault_i == 64'h0) && (sat_fault_i == 32'h0);
  // Three pin stages, the agreement filter and the alert flop need six samples in all.
  sequence s_chan_held;
    (chan_fault_i != 64'h0) [*6];
  endsequence
  sequence s_sat_held;
    (sat_fault_i != 32'h0) [*6];
  endsequence
  sequence s_soft_done;
    soft_reset_o ##1 !soft_reset_o [*8];
  endsequence
  a_alert_header_same: assert property (fault_alert_out_o == header_fault_o)
    else $error("alert and header fault bit differ");
  a_chan_raises_alert: assert property (s_chan_held |-> fault_alert_out_o)
    else $error("channel fault did not raise alert");
  a_sat_raises_alert: assert property (s_sat_held |-> fault_alert_out_o)
    else $error("saturation fault did not raise alert");
  a_reset_clears_out: assert property (disable iff (1'b0) !rstn_i |=> !fault_alert_out_o && !soft_reset_o)
    else $error("outputs not cleared by reset");
  a_reset_no_alert: assert property (($rose(rstn_i) && raw_quiet) |-> !fault_alert_out_o [*3])
    else $error("reset seen flag raised the alert");
  a_soft_single_pulse: assert property (soft_reset_o |-> s_soft_done)
    else $error("soft reset pulse too long");
  a_soft_clears_aux: assert property (soft_reset_o |-> ##[0:12] !aux_power_on_o)
    else $error("soft reset kept aux power on");
  a_alert_fall_quiet: assert property ($fell(fault_alert_out_o) |-> $past(raw_quiet))
    else $error("alert fell while a raw fault stood");
endmodule
bind srp_port srp_monitor u_mon (.mclk_i, .rstn_i, .chan_fault_i, .sat_fault_i, .fault_alert_out_o, .header_fault_o,
  .aux_power_on_o, .soft_reset_o);
`default_nettype wire

// ### dv/srp_host.sv
// Serial host model that frames transfers in clock mode 0/0 or 1/1.
`timescale 1ns/10ps
`default_nettype none
module srp_host (
  input wire logic sdo_i,
  input wire logic cpol_i,
  output var logic sclk_o,
  output var logic cs_n_o,
  output var logic sdi_o
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
  end
  // The port's reset passes serial flops, so reset needs edges with select high.
  task automatic pump(input int n);
    repeat (n) begin
      #80 sclk_o = 1'b1;
      #80 sclk_o = 1'b0;
    end
  endtask
  task automatic xfer(input logic [63:0] tx, input int n, output logic [63:0] rx);
    rx = 64'h0;
    // The idle level settles before select falls, so no edge races the frame start.
    sclk_o = cpol_i;
    #40 cs_n_o = 1'b0;
    for (int k = n - 1; k >= 0; k--) begin
      sclk_o = 1'b0;
      sdi_o = tx[k];
      // The port launches each output bit on a rising edge, so it is taken just before the next one.
      #70 rx[k] = sdo_i;
      #10 sclk_o = 1'b1;
      #80;
    end
    sclk_o = cpol_i;
    #80 cs_n_o = 1'b1;
    // A released line must not keep looking like the last bit.
    sdi_o = ~sdi_o;
    #200;
  endtask
endmodule
`default_nettype wire

// ### dv/test_srp_port.sv
// Self-checking bench for the serial register port.
`timescale 1ns/10ps
`default_nettype none
module test_srp_port;
  localparam int LIMIT = 60000;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic sync_in_i = 1'b0;
  logic handover_fail_i = 1'b0;
  logic [2:0] reg_mon_i = 3'h0;
  logic [63:0] chan_fault_i = 64'h0;
  logic [31:0] sat_fault_i = 32'h0;
  logic [63:0] main_data_i = 64'h0;
  logic main_valid_i = 1'b0;
  logic [11:0] aux_data_i = 12'h000;
  logic aux_valid_i = 1'b0;
  logic cpol = 1'b0;
  wire logic sclk_i, cs_n_i, sdi_i, sdo_o, fault_alert_out_o, header_fault_o, aux_power_on_o, soft_reset_o;
  int n_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int n_soft = 0;
  logic [63:0] rx;
  logic [63:0] acc;
  always #5 mclk_i = ~mclk_i;
  srp_port u_dut (.mclk_i, .rstn_i, .sclk_i, .cs_n_i, .sdi_i, .sync_in_i, .handover_fail_i, .reg_mon_i,
    .chan_fault_i, .sat_fault_i, .main_data_i, .main_valid_i, .aux_data_i, .aux_valid_i, .sdo_o,
    .fault_alert_out_o, .header_fault_o, .aux_power_on_o, .soft_reset_o);
  srp_host u_host (.sdo_i(sdo_o), .cpol_i(cpol), .sclk_o(sclk_i), .cs_n_o(cs_n_i), .sdi_o(sdi_i));
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cycles++;
    if (soft_reset_o === 1'b1) n_soft++;
    if (cycles == LIMIT) begin
      n_errors++;
      complete_run();
    end
  end
  task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  function automatic logic [7:0] crc8(input logic [15:0] m);
    crc8 = 8'h00;
    for (int i = 15; i >= 0; i--) begin
      crc8 = {crc8[6:0], 1'b0} ^ (((crc8[7] ^ m[i]) == 1'b1) ? 8'h07 : 8'h00);
    end
  endfunction
  task automatic rchk(input logic [6:0] a, input logic [7:0] d);
    u_host.xfer({48'h0, 1'b1, a, 8'h00}, 16, rx);
    chk("read", rx[15:0], {8'h20, d});
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_host.xfer({48'h0, 1'b0, a, d}, 16, rx);
    chk("write", rx[15:0], 16'h2000);
  endtask
  task automatic cx(input logic [15:0] m, input logic [7:0] flip, input logic [15:0] em);
    u_host.xfer({40'h0, m, crc8(m) ^ flip}, 24, rx);
    chk("crc frame", rx[23:0], {em, crc8(em)});
  endtask
  task automatic alert(input logic e);
    tick(12);
    chk("alert", fault_alert_out_o, e);
  endtask
  initial begin
    u_host.pump(4);
    @(posedge mclk_i) rstn_i <= 1'b1;
    // The serial side leaves reset two clock edges after release, so it gets them before a frame.
    u_host.pump(3);
    tick(10);
    rchk(7'h09, 8'h02);
    rchk(7'h09, 8'h00);
    alert(1'b0);
    rchk(7'h05, 8'h07);
    wr(7'h00, 8'h08);
    chk("aux power", aux_power_on_o, 1'b1);
    wr(7'h18, 8'h11);
    alert(1'b1);
    rchk(7'h30, 8'h00);
    rchk(7'h08, 8'h06);
    alert(1'b0);
    @(posedge mclk_i) handover_fail_i <= 1'b1;
    alert(1'b1);
    rchk(7'h09, 8'h01);
    rchk(7'h17, 8'h42);
    wr(7'h04, 8'h01);
    rchk(7'h09, 8'h00);
    alert(1'b0);
    @(posedge mclk_i) handover_fail_i <= 1'b0;
    wr(7'h04, 8'h00);
    @(posedge mclk_i) reg_mon_i <= 3'h2;
    alert(1'b1);
    rchk(7'h09, 8'h08);
    wr(7'h05, 8'h05);
    alert(1'b0);
    @(posedge mclk_i) reg_mon_i <= 3'h0;
    wr(7'h05, 8'h07);
    wr(7'h06, 8'h01);
    alert(1'b1);
    rchk(7'h09, 8'h04);
    wr(7'h06, 8'h00);
    alert(1'b0);
    @(posedge mclk_i) chan_fault_i <= 64'h0000_0000_1000_0000;
    @(posedge mclk_i) sat_fault_i <= 32'h0000_0100;
    alert(1'b1);
    rchk(7'h0d, 8'h10);
    rchk(7'h13, 8'h01);
    rchk(7'h16, 8'h08);
    rchk(7'h17, 8'h48);
    @(posedge mclk_i) chan_fault_i <= 64'h0;
    @(posedge mclk_i) sat_fault_i <= 32'h0;
    alert(1'b0);
    rchk(7'h17, 8'h40);
    rchk(7'h17, 8'h00);
    wr(7'h03, 8'h01);
    cx({1'b0, 7'h07, 8'h5a}, 8'h00, 16'h2000);
    cx({1'b0, 7'h07, 8'ha5}, 8'h01, 16'h2000);
    cx({1'b1, 7'h07, 8'h00}, 8'h00, 16'h205a);
    cx({1'b1, 7'h08, 8'h00}, 8'h00, 16'h2001);
    cx({1'b0, 7'h03, 8'h00}, 8'h00, 16'h2000);
    @(posedge mclk_i) aux_data_i <= 12'habc;
    @(posedge mclk_i) aux_valid_i <= 1'b1;
    @(posedge mclk_i) aux_valid_i <= 1'b0;
    wr(7'h01, 8'h20);
    u_host.xfer(64'h8000, 16, rx);
    chk("aux", rx[15:0], 16'h2abc);
    @(posedge mclk_i) aux_data_i <= 12'h123;
    @(posedge mclk_i) aux_valid_i <= 1'b1;
    @(posedge mclk_i) aux_valid_i <= 1'b0;
    u_host.xfer({48'h0, 1'b0, 7'h07, 8'h33}, 16, rx);
    chk("aux write", rx[15:0], 16'h2123);
    u_host.xfer({48'h0, 1'b1, 7'h30, 8'h00}, 16, rx);
    alert(1'b0);
    u_host.xfer({48'h0, 1'b0, 7'h01, 8'h00}, 16, rx);
    rchk(7'h07, 8'h33);
    wr(7'h02, 8'h10);
    @(posedge mclk_i) main_data_i <= 64'h0123456789abcdef;
    @(posedge mclk_i) main_valid_i <= 1'b1;
    @(posedge mclk_i) main_valid_i <= 1'b0;
    acc = 64'h0;
    for (int k = 0; k < 8; k++) begin
      u_host.xfer((k == 0) ? 64'h80 : 64'h00, 8, rx);
      acc = {acc[55:0], rx[7:0]};
    end
    chk("main", acc, 64'h0123456789abcdef);
    u_host.xfer({48'h0, 1'b0, 7'h02, 8'h00}, 16, rx);
    rchk(7'h02, 8'h00);
    u_host.xfer({64{1'b1}}, 64, rx);
    tick(12);
    chk("soft pulses", n_soft, 1);
    chk("aux power", aux_power_on_o, 1'b0);
    rchk(7'h07, 8'h00);
    rchk(7'h05, 8'h07);
    cpol = 1'b1;
    wr(7'h07, 8'h3c);
    rchk(7'h07, 8'h3c);
    cpol = 1'b0;
    u_host.xfer({48'h0, 1'b1, 7'h08, 8'h00}, 16, rx);
    @(posedge mclk_i) sync_in_i <= 1'b1;
    tick(10);
    rchk(7'h09, 8'h00);
    complete_run();
  end
endmodule
`default_nettype wire
